// file: design/sarseq_top.v
// Successive-approximation converter sequencer with APB registers.
// Assumes an analog core that samples while sample_hold is high and
// compares against sar_trial, returning comp_in asynchronously.
//
// The placing of the registers and the APB slave port were chosen for this implementation.
`timescale 1ns/100ps
`include "sarseq_regs.vh"
module sarseq_top #(
   parameter [11:0] FACTORY_OFFSET = 12'h000, // Trimmed at test
   parameter [11:0] FACTORY_GAIN   = 12'h000  // Trimmed at test
) (
   pclk,
   presetn,
   psel,
   penable,
   pwrite,
   paddr,
   pwdata,
   prdata,
   pready,
   pslverr,
   convert_start_pin,
   pla_trigger,
   timer0_overflow,
   timer1_overflow,
   comp_in,
   sample_hold,
   sar_trial,
   busy,
   input_mode,
   pos_channel,
   neg_channel,
   pos_buf_bypass,
   neg_buf_bypass,
   neg_drive_disable,
   pga_enable,
   pga_gain
);
   input  wire        pclk;              // Bus clock, 100 MHz
   input  wire        presetn;           // Asynchronous reset, active low
   input  wire        psel;              // APB select
   input  wire        penable;           // APB access phase
   input  wire        pwrite;            // APB direction
   input  wire [7:0]  paddr;             // APB byte address
   input  wire [31:0] pwdata;            // APB write data
   output reg  [31:0] prdata;            // APB read data
   output reg         pready;            // APB ready
   output reg         pslverr;           // Unmapped address
   input  wire        convert_start_pin; // External trigger pin, level
   input  wire        pla_trigger;       // Logic array output, level
   input  wire        timer0_overflow;   // One-cycle pulse
   input  wire        timer1_overflow;   // One-cycle pulse
   input  wire        comp_in;           // Analog comparator, async
   output reg         sample_hold;       // High while acquiring
   output reg  [11:0] sar_trial;         // Capacitor DAC trial word
   output reg         busy;              // High during a conversion
   output reg  [1:0]  input_mode;        // Mode to the analog front end
   output reg  [4:0]  pos_channel;       // Positive multiplexer
   output reg  [4:0]  neg_channel;       // Negative multiplexer
   output reg         pos_buf_bypass;    // Positive buffer bypassed
   output reg         neg_buf_bypass;    // Negative buffer bypassed
   output reg         neg_drive_disable; // Amplified negative driver off
   output reg         pga_enable;        // Amplifier in the path
   output reg  [4:0]  pga_gain;          // Amplifier gain step

   localparam [1:0] ST_IDLE = 2'h0;      // Waiting for a trigger
   localparam [1:0] ST_ACQ  = 2'h1;      // Tracking the input
   localparam [1:0] ST_BIT  = 2'h2;      // Bit trials
   localparam [1:0] ST_WR   = 2'h3;      // Result write clocks

   reg  [15:0] conv_control;             // Control register
   reg  [11:0] offset_coeff;             // Offset coefficient
   reg  [11:0] gain_coeff;               // Gain coefficient
   reg  [31:0] conv_result;              // Formatted result
   reg         result_ready_flag;        // Conversion finished, unread
   reg         temp_timing;              // Forced timing held until read
   reg  [1:0]  state;                    // Sequencer state
   reg  [4:0]  count;                    // Clocks left in the phase
   reg  [3:0]  bit_idx;                  // Bit under trial
   reg  [11:0] raw;                      // Accumulated trial result
   reg  [1:0]  conv_mode;                // Mode latched at start
   reg         pin_s1, pin_s2;           // Pin synchroniser
   reg         cmp_s1, cmp_s2;           // Comparator synchroniser
   reg         trig_d;                   // Trigger level last cycle
   reg         pend_single;              // Software start waiting
   wire [2:0]  trig_src;                 // Selected trigger source
   wire        trig_level;               // Level-type trigger now
   wire        start;                    // Begin a conversion
   wire [2:0]  div_code, acq_code;       // Effective timing codes
   wire        tick;                     // Converter clock enable
   wire        corr_done;                // Corrected code ready
   wire [11:0] corr_code;                // Corrected code
   wire [11:0] signed_code;              // Differential, shifted
   wire        wr_en, rd_en;             // Bus write and read strobes
   wire        is_temp;                  // Temperature channel chosen

   // Address decode, shared by the read mux and the error answer
   function mapped;
      input [7:0] a;
      begin
         mapped = (a[1:0] == 2'b00) && (a[7:2] <= 6'h08);
      end
   endfunction

   // Refused addresses neither write nor clear anything by a read
   assign wr_en    = psel & penable & pready & pwrite & mapped(paddr);
   assign rd_en    = psel & penable & pready & ~pwrite & mapped(paddr);
   assign trig_src = conv_control[`SARSEQ_CTL_TRIG_HI:`SARSEQ_CTL_TRIG_LO];
   assign is_temp  = (pos_channel == `SARSEQ_PCH_TEMP);
   // Temperature conversions override the user timing fields
   assign div_code = (is_temp | temp_timing) ? `SARSEQ_TEMP_DIV :
                     conv_control[`SARSEQ_CTL_DIV_HI:`SARSEQ_CTL_DIV_LO];
   assign acq_code = (is_temp | temp_timing) ? `SARSEQ_TEMP_ACQ :
                     conv_control[`SARSEQ_CTL_ACQ_HI:`SARSEQ_CTL_ACQ_LO];

   // Level triggers: pin (synchronised) or logic array output
   assign trig_level = (trig_src == `SARSEQ_TRIG_PIN) ? pin_s2 :
                       (trig_src == `SARSEQ_TRIG_PLA) ? pla_trigger :
                       1'b0;

   // Any start source, taken only in idle
   assign start = (state == ST_IDLE) & (
      pend_single |
      (trig_src == `SARSEQ_TRIG_CONT) |
      (trig_level & ~trig_d) |
      (trig_level & busy) |
      ((trig_src == `SARSEQ_TRIG_TMR0) & timer0_overflow) |
      ((trig_src == `SARSEQ_TRIG_TMR1) & timer1_overflow));

   // Differential: offset binary to twos complement, halved
   assign signed_code = $signed({~corr_code[11], corr_code[10:0]}) >>> 1;

   sarseq_clkdiv u_div (
      .pclk    (pclk),
      .presetn (presetn),
      .code    (div_code),
      .tick    (tick)
   );

   sarseq_correct u_corr (
      .pclk    (pclk),
      .presetn (presetn),
      // A tick every cycle must not launch a second correction
      .go      ((state == ST_WR) & tick & (count == 5'h00) & ~corr_done),
      .raw     (raw),
      .offset  (offset_coeff),
      .gain    (gain_coeff),
      .done    (corr_done),
      .code    (corr_code)
   );

   // Two flip-flops on the pin and comparator before any use
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_s1 <= 1'b0;
         pin_s2 <= 1'b0;
         cmp_s1 <= 1'b0;
         cmp_s2 <= 1'b0;
         trig_d <= 1'b0;
      end else begin
         pin_s1 <= convert_start_pin;
         pin_s2 <= pin_s1;
         cmp_s1 <= comp_in;
         cmp_s2 <= cmp_s1;
         trig_d <= trig_level;
      end
   end

   // APB slave: ready in the first access cycle, read data with it
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h00000000;
      end else begin
         pready  <= psel & ~penable & ~pready;
         pslverr <= psel & ~penable & ~mapped(paddr);
         if (psel & ~penable & ~pwrite) begin
            // Unmapped reads fall to the default and return zero
            case (mapped(paddr) ? paddr[7:2] : 6'h3f)
               6'h00:   prdata <= {16'h0000, conv_control};
               6'h01:   prdata <= {27'h0, pos_channel};
               6'h02:   prdata <= {27'h0, neg_channel};
               6'h03:   prdata <= {30'h0, busy, result_ready_flag};
               6'h04:   prdata <= conv_result;
               6'h05:   prdata <= {20'h0, offset_coeff};
               6'h06:   prdata <= {20'h0, gain_coeff};
               6'h08:   prdata <= {27'h0, pga_gain};
               default: prdata <= 32'h00000000;
            endcase
         end
      end
   end

   // Configuration registers; a reset-register write restores defaults
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         conv_control <= `SARSEQ_CTL_RESET;
         pos_channel  <= 5'h00;
         neg_channel  <= 5'h00;
         offset_coeff <= FACTORY_OFFSET;
         gain_coeff   <= FACTORY_GAIN;
         pga_gain     <= `SARSEQ_PGA_RESET;
      end else if (wr_en && paddr[7:2] == 6'h07) begin
         conv_control <= `SARSEQ_CTL_RESET;
         pos_channel  <= 5'h00;
         neg_channel  <= 5'h00;
         offset_coeff <= FACTORY_OFFSET;
         gain_coeff   <= FACTORY_GAIN;
         pga_gain     <= `SARSEQ_PGA_RESET;
      end else if (wr_en) begin
         case (paddr[7:2])
            // Start bit is a command and never stored
            6'h00:   conv_control <= pwdata[15:0] &
                                     ~(16'h0001 << `SARSEQ_CTL_START);
            6'h01:   pos_channel  <= pwdata[4:0];
            6'h02:   neg_channel  <= pwdata[4:0];
            6'h05:   offset_coeff <= pwdata[11:0];
            6'h06:   gain_coeff   <= pwdata[11:0];
            6'h08:   pga_gain     <= pwdata[4:0];
            default: ;
         endcase
      end
   end

   // Front-end controls follow the registers directly
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         input_mode        <= `SARSEQ_MODE_SE;
         pos_buf_bypass    <= 1'b0;
         neg_buf_bypass    <= 1'b0;
         neg_drive_disable <= 1'b0;
         pga_enable        <= 1'b0;
      end else begin
         input_mode <= conv_control[`SARSEQ_CTL_MODE_HI:
                                    `SARSEQ_CTL_MODE_LO];
         pos_buf_bypass    <= conv_control[`SARSEQ_CTL_PBYP];
         neg_buf_bypass    <= conv_control[`SARSEQ_CTL_NBYP];
         neg_drive_disable <= conv_control[`SARSEQ_CTL_NBYP];
         // Amplified channels always pass through the amplifier
         pga_enable <= (pos_channel == `SARSEQ_PCH_AMP_A) |
                       (pos_channel == `SARSEQ_PCH_AMP_B);
      end
   end

   // Sequencer: acquisition, twelve bit trials, result write clocks
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state       <= ST_IDLE;
         count       <= 5'h00;
         bit_idx     <= 4'h0;
         raw         <= 12'h000;
         sar_trial   <= 12'h000;
         sample_hold <= 1'b0;
         busy        <= 1'b0;
         conv_mode   <= `SARSEQ_MODE_SE;
         pend_single <= 1'b0;
      end else begin
         if (wr_en && paddr[7:2] == 6'h00 &&
             pwdata[`SARSEQ_CTL_START])
            pend_single <= 1'b1;
         else if (start | (wr_en && paddr[7:2] == 6'h07))
            pend_single <= 1'b0;
         case (state)
            ST_IDLE: begin
               busy <= 1'b0;
               if (start) begin
                  state       <= ST_ACQ;
                  busy        <= 1'b1;
                  sample_hold <= 1'b1;
                  // The register, not the output that lags it a cycle
                  conv_mode   <= conv_control[`SARSEQ_CTL_MODE_HI:
                                              `SARSEQ_CTL_MODE_LO];
                  count       <= 5'h02 << acq_code;
               end
            end
            ST_ACQ: if (tick) begin
               if (count == 5'h01) begin
                  state       <= ST_BIT;
                  sample_hold <= 1'b0;
                  bit_idx     <= 4'hb;
                  raw         <= 12'h000;
                  sar_trial   <= 12'h800;
               end else begin
                  count <= count - 5'h01;
               end
            end
            ST_BIT: if (tick) begin
               // Keep the trial bit when the input is above the DAC
               raw[bit_idx] <= cmp_s2;
               if (bit_idx == 4'h0) begin
                  state     <= ST_WR;
                  count     <= {1'b0, `SARSEQ_WRITE_CLKS};
                  sar_trial <= 12'h000;
               end else begin
                  bit_idx   <= bit_idx - 4'h1;
                  sar_trial <= (sar_trial &
                                ~(12'h001 << bit_idx)) |
                               ({11'h0, cmp_s2} << bit_idx) |
                               (12'h001 << (bit_idx - 4'h1));
               end
            end
            ST_WR: begin
               if (tick && count != 5'h00)
                  count <= count - 5'h01;
               if (corr_done)
                  state <= ST_IDLE;
            end
            default: state <= ST_IDLE;
         endcase
      end
   end

   // Result formatting, ready flag and forced-timing latch
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         conv_result       <= 32'h00000000;
         result_ready_flag <= 1'b0;
         temp_timing       <= 1'b0;
      end else begin
         if (corr_done) begin
            if (conv_mode == `SARSEQ_MODE_DIFF)
               conv_result <= {{4{signed_code[11]}}, signed_code,
                               16'h0000};
            else
               conv_result <= {4'h0, corr_code, 16'h0000};
         end
         // Set wins over the clear of a simultaneous read
         if (corr_done)
            result_ready_flag <= 1'b1;
         else if (rd_en && paddr[7:2] == 6'h04)
            result_ready_flag <= 1'b0;
         if (start & is_temp)
            temp_timing <= 1'b1;
         else if (rd_en && paddr[7:2] == 6'h04 && state == ST_IDLE)
            temp_timing <= 1'b0;
      end
   end
endmodule // sarseq_top

// file: shared/sarseq_regs.vh
// Register map, field positions, reset values and timing counts of the
// converter sequencer; included only by the top-level sequencer module.
`ifndef SARSEQ_REGS_VH
`define SARSEQ_REGS_VH
// Byte offsets on the APB bus
`define SARSEQ_OFS_CONTROL  6'h00
`define SARSEQ_OFS_POSSEL   6'h04
`define SARSEQ_OFS_NEGSEL   6'h08
`define SARSEQ_OFS_STATUS   6'h0c
`define SARSEQ_OFS_RESULT   6'h10
`define SARSEQ_OFS_OFFSET   6'h14
`define SARSEQ_OFS_GAIN     6'h18
`define SARSEQ_OFS_REGRST   6'h1c
`define SARSEQ_OFS_PGAGAIN  6'h20
// Control register fields
`define SARSEQ_CTL_TRIG_LO  0
`define SARSEQ_CTL_TRIG_HI  2
`define SARSEQ_CTL_MODE_LO  3
`define SARSEQ_CTL_MODE_HI  4
`define SARSEQ_CTL_START    5
`define SARSEQ_CTL_DIV_LO   8
`define SARSEQ_CTL_DIV_HI   10
`define SARSEQ_CTL_ACQ_LO   11
`define SARSEQ_CTL_ACQ_HI   13
`define SARSEQ_CTL_NBYP     14
`define SARSEQ_CTL_PBYP     15
`define SARSEQ_CTL_RESET    16'h1100
// Trigger sources
`define SARSEQ_TRIG_SINGLE  3'h0
`define SARSEQ_TRIG_CONT    3'h1
`define SARSEQ_TRIG_PIN     3'h2
`define SARSEQ_TRIG_PLA     3'h3
`define SARSEQ_TRIG_TMR0    3'h4
`define SARSEQ_TRIG_TMR1    3'h5
// Input modes
`define SARSEQ_MODE_SE      2'h0
`define SARSEQ_MODE_DIFF    2'h1
`define SARSEQ_MODE_PSEUDO  2'h2
// Positive selections
`define SARSEQ_PCH_AMP_A    5'h0b
`define SARSEQ_PCH_AMP_B    5'h0c
`define SARSEQ_PCH_IOMON    5'h0d
`define SARSEQ_PCH_TEMP     5'h0e
`define SARSEQ_PCH_VREF     5'h0f
`define SARSEQ_PCH_AGND     5'h10
// Negative selections
`define SARSEQ_NCH_CM       5'h0b
`define SARSEQ_NCH_AMPNEG   5'h0c
`define SARSEQ_NCH_AGND     5'h0d
// Forced timing on the temperature channel: acq 16, divider 32
`define SARSEQ_TEMP_ACQ     3'h3
`define SARSEQ_TEMP_DIV     3'h5
// Converter clocks spent writing the result after the bit trials
`define SARSEQ_BITS         12
`define SARSEQ_WRITE_CLKS   4'h2
`define SARSEQ_PGA_RESET    5'h00
`endif

// file: design/sarseq_clkdiv.v
// Converter clock divider: one-cycle enable every 2^code pclk cycles.
// Assumes pclk/presetn of the sequencer; code may change at any time.
`timescale 1ns/100ps
module sarseq_clkdiv (
   pclk,
   presetn,
   code,
   tick
);
   input  wire       pclk;    // Bus clock
   input  wire       presetn; // Asynchronous reset, active low
   input  wire [2:0] code;    // Divide by 2^code
   output reg        tick;    // One-cycle converter clock enable

   reg  [7:0] count;          // Free-running prescaler
   wire [7:0] mask;           // Low bits that must all be ones

   assign mask = (8'h01 << code) - 8'h01;

   // Tick when the low code bits wrap; code 0 ticks every cycle
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         count <= 8'h00;
         tick  <= 1'b0;
      end else begin
         count <= count + 8'h01;
         tick  <= ((count & mask) == mask);
      end
   end
endmodule // sarseq_clkdiv

// file: design/sarseq_correct.v
// Digital offset and gain correction of a raw 12-bit code.
// Assumes raw/go come from the same pclk domain; result one cycle later.
`timescale 1ns/100ps
module sarseq_correct (
   pclk,
   presetn,
   go,
   raw,
   offset,
   gain,
   done,
   code
);
   input  wire        pclk;    // Bus clock
   input  wire        presetn; // Asynchronous reset, active low
   input  wire        go;      // Raw code valid, one cycle
   input  wire [11:0] raw;     // Unsigned code from the bit trials
   input  wire [11:0] offset;  // Signed, quarter-LSB steps
   input  wire [11:0] gain;    // Signed, quarter-LSB steps at full scale
   output reg         done;    // Corrected code valid, one cycle
   output reg  [11:0] code;    // Corrected, clamped code

   wire signed [15:0] quarter; // Code in quarter LSBs plus offset
   wire signed [29:0] prod;    // Gain term before scaling
   wire signed [17:0] fixed;   // Quarter LSBs after both corrections

   assign quarter = $signed({2'b00, raw, 2'b00}) +
                    $signed({{4{offset[11]}}, offset});
   assign prod    = $signed({{14{quarter[15]}}, quarter}) *
                    $signed({{18{gain[11]}}, gain});
   // One gain step moves full scale (16384 quarters) by one quarter
   assign fixed   = $signed({{2{quarter[15]}}, quarter}) +
                    $signed(prod[29:14]);

   // Truncate to whole LSBs and clamp to the code range
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         done <= 1'b0;
         code <= 12'h000;
      end else begin
         done <= go;
         if (go) begin
            if (fixed[17])
               code <= 12'h000;
            else if (fixed[16:14] != 3'b000)
               code <= 12'hfff;
            else
               code <= fixed[13:2];
         end
      end
   end
endmodule // sarseq_correct

// file: verification/sarseq_assertions.sv
// Port checker for the converter sequencer: bus handshake and front end.
// Assumes it is bound onto sarseq_top; one clock, async active-low reset.
`timescale 1ns/100ps
module sarseq_chk (
   input wire        pclk,
   input wire        presetn,
   input wire        psel,
   input wire        penable,
   input wire        pwrite,
   input wire [7:0]  paddr,
   input wire [31:0] prdata,
   input wire        pready,
   input wire        pslverr,
   input wire        busy,
   input wire        sample_hold,
   input wire [1:0]  input_mode,
   input wire [4:0]  pos_channel,
   input wire        neg_buf_bypass,
   input wire        neg_drive_disable,
   input wire        pga_enable
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // Wait-free slave: answer in the first access cycle, for one cycle
   ack_first_a: assert property ($rose(penable) && psel |-> pready)
      else $error("ready missing in first access cycle");
   ack_single_a: assert property (pready |=> !pready)
      else $error("ready held longer than one cycle");
   // Refusals only come with an answer, and never leak data
   err_with_ack_a: assert property (pslverr |-> pready && psel && penable)
      else $error("error without a bus answer");
   bad_addr_a: assert property (psel && penable
      && (paddr > 8'h20 || paddr[1:0] != 2'h0) |-> pslverr)
      else $error("unmapped address accepted");
   err_read_a: assert property (pslverr && !pwrite |-> prdata == 32'h0)
      else $error("refused read returned data");
   sign_ext_a: assert property (pready && !pwrite && paddr == 8'h10
      && input_mode == 2'h1 |-> prdata[31:28] == {4{prdata[27]}})
      else $error("result sign bits not extended");
   // A conversion keeps busy high for at least eight cycles
   busy_min_a: assert property ($rose(busy) |-> busy[*8])
      else $error("busy pulse too short");
   hold_in_busy_a: assert property (sample_hold |-> busy)
      else $error("acquiring outside a conversion");
   neg_pair_a: assert property (neg_buf_bypass == neg_drive_disable)
      else $error("negative bypass and driver disagree");
   // An amplified channel in the register turns amplifier control on one cycle later
   pga_path_a: assert property ((pos_channel == 5'h0b
      || pos_channel == 5'h0c) |=> pga_enable)
      else $error("amplifier bypassed on amplified channel");
endmodule // sarseq_chk

bind sarseq_top sarseq_chk i_chk (.pclk(pclk), .presetn(presetn),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .prdata(prdata), .pready(pready), .pslverr(pslverr), .busy(busy),
   .sample_hold(sample_hold), .input_mode(input_mode),
   .pos_channel(pos_channel), .neg_buf_bypass(neg_buf_bypass),
   .neg_drive_disable(neg_drive_disable), .pga_enable(pga_enable));

// file: verification/test_sar_adc_sequencer.sv
// Self-checking bench for the sequencer: APB tasks and directed tests.
// Assumes the comparator level is driven directly; all results are exact.
`timescale 1ns/100ps
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin n_fail++; \
 $display("Error at %0t: got %h expected %h", $time, (a), (e)); end end
module test_sar_adc_sequencer;
   logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic [7:0]  paddr = 0;         // Byte address
   logic [31:0] pwdata = 0, rd;    // Write data, last read data
   logic        err, cpin = 0, programmable_logic_array = 0, t0 = 0, t1 = 0, comp = 0;
   int          n_fail = 0, samples_checked = 0, cnt;
   wire [31:0]  prdata;
   wire [11:0]  trial;
   wire [4:0]   pch, nch, gain;
   wire [1:0]   mode;
   wire         pready, pslverr, sh, busy, pbyp, nbyp, ndis, gain_amplifier;
   // Factory trims are arbitrary, only to see them after reset
   sarseq_top #(.FACTORY_OFFSET(12'h005), .FACTORY_GAIN(12'h003)) i_dut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .convert_start_pin(cpin),
      .pla_trigger(programmable_logic_array), .timer0_overflow(t0), .timer1_overflow(t1),
      .comp_in(comp), .sample_hold(sh), .sar_trial(trial), .busy(busy),
      .input_mode(mode), .pos_channel(pch), .neg_channel(nch),
      .pos_buf_bypass(pbyp), .neg_buf_bypass(nbyp),
      .neg_drive_disable(ndis), .pga_enable(gain_amplifier), .pga_gain(gain));
   // 100 MHz bus clock
   initial begin
      forever #5 pclk = ~pclk;
   end
   task report_and_stop;
      $display("checks %0d mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   // One APB transfer; the idle edge after it avoids double assignment
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      int n;
      n = 0;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (pready !== 1'b1) begin
         n_fail++;
         report_and_stop;
      end
      @(posedge pclk);
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task rc(input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      `CHK(rd, e)
   endtask
   // Bounded wait for busy to reach a level; cnt holds the cycles taken
   task wait_busy(input logic v);
      cnt = 0;
      while (busy !== v && cnt < 3000) begin
         @(posedge pclk);
         cnt++;
      end
      if (busy !== v) begin
         n_fail++;
         report_and_stop;
      end
   endtask
   // Start one conversion, wait for it, check ready, fetch the result
   task conv(input logic [31:0] ctl);
      wr(8'h00, ctl);
      wait_busy(1'b1);
      wait_busy(1'b0);
      `CHK({sh, trial}, 13'h0)
      rc(8'h0c, 32'h1);
      apb(1'b0, 8'h10, 32'h0);
   endtask
   initial begin
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      rc(8'h00, 32'h1100);
      rc(8'h14, 32'h5);
      rc(8'h18, 32'h3);
      rc(8'h24, 32'h0);
      `CHK(err, 1'b1)
      $display("test defaults done");
      wr(8'h04, 32'h0b);
      wr(8'h20, 32'h1f);
      wr(8'h00, 32'hd110);
      // Front-end outputs lag the control register by one cycle
      @(posedge pclk);
      `CHK({mode, pch, pbyp, nbyp, gain_amplifier, gain}, {2'h2, 5'h0b, 3'h7, 5'h1f})
      wr(8'h00, 32'h9110);
      wr(8'h04, 32'h03);
      wr(8'h08, 32'h0b);
      `CHK(nch, 5'h0b)
      `CHK({mode, pch, pbyp, nbyp, ndis}, {2'h2, 5'h03, 3'h4})
      $display("test front end done");
      wr(8'h14, 32'h0);
      wr(8'h18, 32'h0);
      comp <= 1'b1;
      conv(32'h1120);
      `CHK(rd[27:16], 12'hfff)
      conv(32'h1128);
      `CHK(rd[31:16], 16'h03ff)
      comp <= 1'b0;
      conv(32'h1128);
      `CHK(rd[31:16], 16'hfc00)
      rc(8'h0c, 32'h0);
      wr(8'h14, 32'h8);
      conv(32'h1130);
      `CHK(rd[27:16], 12'h002)
      wr(8'h14, 32'h0);
      wr(8'h18, 32'hc00);
      comp <= 1'b1;
      conv(32'h1120);
      `CHK(rd[27:16], 12'heff)
      $display("test results done");
      for (int t = 1; t < 6; t++) begin
         wr(8'h00, 32'h1100 | t);
         cpin <= (t == 2);
         programmable_logic_array <= (t == 3);
         t0 <= (t == 4);
         t1 <= (t == 5);
         @(posedge pclk);
         t0 <= 1'b0;
         t1 <= 1'b0;
         wait_busy(1'b1);
         // Continuous and level triggers restart back to back, so busy never drops; timer triggers do not
         cnt = 0;
         repeat (200) begin
            @(posedge pclk);
            cnt += busy;
         end
         `CHK(cnt == 200, t < 4)
         cpin <= 1'b0;
         programmable_logic_array <= 1'b0;
         wr(8'h00, 32'h1100);
         wait_busy(1'b0);
         repeat (100) @(posedge pclk);
         `CHK(busy, 1'b0)
      end
      $display("test triggers done");
      wr(8'h04, 32'h0e);
      conv(32'h1120);
      `CHK(cnt > 500, 1'b1)
      wr(8'h04, 32'h03);
      conv(32'h1120);
      `CHK(cnt < 200, 1'b1)
      $display("test temperature done");
      wr(8'h20, 32'h7);
      wr(8'h1c, 32'h1);
      rc(8'h00, 32'h1100);
      rc(8'h14, 32'h5);
      rc(8'h20, 32'h0);
      $display("test register reset done");
      report_and_stop;
   end
endmodule // test_sar_adc_sequencer
